// ===== verilog/adcd_pkg.sv
package adcd_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ      = 10;
  // Least time of one calibration step
  localparam int unsigned CAL_STEP_NS  = 2000;
  localparam int unsigned CAL_STEP_CYC = (CAL_STEP_NS * CLK_MHZ + 999) / 1000;
  // Least time of one conversion
  localparam int unsigned CONV_NS      = 3000;
  localparam int unsigned CONV_CYC     = (CONV_NS * CLK_MHZ + 999) / 1000;
  // Counter width and reload values
  localparam int unsigned CNT_W        = 6;
  localparam logic [5:0]  CAL_LD       = 6'(CAL_STEP_CYC - 1);
  localparam logic [5:0]  CONV_LD      = 6'(CONV_CYC - 1);

  // Register address map
  localparam logic        ADDR_CTRL    = 1'h0;
  // Values after reset
  localparam logic [13:0] RST_CTRL     = 14'h0000;
  localparam logic [15:0] RST_RDATA    = 16'h0000;
  // Read target that selects the state word
  localparam logic [1:0]  RT_STATE     = 2'h3;
  // Identifier field of the state word
  localparam logic [1:0]  STATE_ID     = 2'h3;
  // Negative input code for analog ground
  localparam logic [3:0]  AIN_GND      = 4'h0;

  // Control word, MSB first
  typedef struct packed {
    logic       input_config_select;
    logic [2:0] channel_sel;
    logic [1:0] power_down_sel;
    logic [1:0] read_target;
    logic       if_mode;
    logic       conv_start;
    logic       cal_kind;
    logic [1:0] cal_target;
    logic       cal_launch;
  } adcd_ctrl_s;

  // Calibration step in progress
  typedef enum logic [1:0] {
    STEP_NONE,
    STEP_DAC,
    STEP_GAIN,
    STEP_OFFS
  } adcd_step_e;

  // Analog input routing
  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } adcd_mux_s;

  // Calibration engine outputs
  typedef struct packed {
    logic       active;
    logic       sys;
    adcd_step_e step;
  } adcd_cal_s;

endpackage

// ===== verilog/adcd_top.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Operation
// - Differential: pairs routed, upper codes swap
// - Single-ended: odd then even, ground negative
// - Self full: DAC, gain, offset; default
// - Self 01: gain then offset
// - Self 10 offset only, 11 gain only
// - System full: DAC, gain, offset
// - System 01: gain then offset
// - System 10 offset only, 11 gain
// - Status read-only, selected by target 11
// - Status bits zero after power-up, except bits 7..6
// - Status bit 15 always zero
// - Bit 14 busy converting or calibrating
// - Bits 13..10 show channel selection
// - Bits 9..8 show power-down selection
// - Bits 7..6 always one
// - Bit 5 mode, cleared every read
// - Bit 3 shows calibration kind
// - Bit 0 shows calibration running
// - Bits 2..1 show calibration selection
// - Launch starts calibration, clears when done
module adcd_top (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  output adcd_pkg::adcd_mux_s    ain_sel,
  output adcd_pkg::adcd_cal_s    cal_state
);

  ////////////////////////////////////////////////////////////////////
  // State

  // Whole state of the block
  typedef struct packed {
    adcd_pkg::adcd_ctrl_s ctrl;     // Control word
    logic [2:0]           plan;     // Steps left: DAC, gain, offset
    logic [5:0]           cal_cnt;  // Cycles left in step
    logic [5:0]           conv_cnt; // Cycles left in conversion
    logic [15:0]          rdata;    // Read data
    adcd_pkg::adcd_mux_s  mux;      // Input routing
    adcd_pkg::adcd_cal_s  cal;      // Calibration outputs
  } adcd_state_s;

  adcd_state_s s_q;                 // Registered state
  adcd_state_s s_d;                 // Next state

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Channel code to input pair
  function automatic adcd_pkg::adcd_mux_s route(
    input logic       sgl,
    input logic [2:0] ch
  );
    adcd_pkg::adcd_mux_s m;
    // Odd inputs for low codes, even for high
    m.pos = 4'({ch[1:0], ch[2]}) + 4'h1;
    if (sgl) begin
      // Single-ended: ground on minus side
      m.neg = adcd_pkg::AIN_GND;
    end else begin
      // Differential: partner of the pair
      m.neg = 4'({ch[1:0], ~ch[2]}) + 4'h1;
    end
    return m;
  endfunction

  // Selection bits to step plan
  function automatic logic [2:0] plan_of(
    input logic [1:0] tgt
  );
    logic [2:0] p;
    case (tgt)
      2'h0:    p = 3'h7;
      2'h1:    p = 3'h3;
      2'h2:    p = 3'h1;
      2'h3:    p = 3'h2;
      default: p = 3'h0;
    endcase
    return p;
  endfunction

  // First step left in a plan
  function automatic adcd_pkg::adcd_step_e first_step(
    input logic [2:0] p
  );
    adcd_pkg::adcd_step_e st;
    // DAC, then gain, then offset
    if (p[2]) begin
      st = adcd_pkg::STEP_DAC;
    end else if (p[1]) begin
      st = adcd_pkg::STEP_GAIN;
    end else if (p[0]) begin
      st = adcd_pkg::STEP_OFFS;
    end else begin
      st = adcd_pkg::STEP_NONE;
    end
    return st;
  endfunction

  // Plan bit of a step
  function automatic logic [2:0] step_bit(
    input adcd_pkg::adcd_step_e st
  );
    logic [2:0] b;
    case (st)
      adcd_pkg::STEP_DAC:  b = 3'h4;
      adcd_pkg::STEP_GAIN: b = 3'h2;
      adcd_pkg::STEP_OFFS: b = 3'h1;
      default:             b = 3'h0;
    endcase
    return b;
  endfunction

  // Build the state word
  function automatic logic [15:0] state_word(
    input adcd_pkg::adcd_ctrl_s c
  );
    logic [15:0] w;
    w = {1'b0,
         c.conv_start | c.cal_launch,
         c.input_config_select,
         c.channel_sel,
         c.power_down_sel,
         adcd_pkg::STATE_ID,
         c.if_mode,
         1'b0,
         c.cal_kind,
         c.cal_target,
         c.cal_launch};
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode

  // Write to the control word
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && (reg_addr == adcd_pkg::ADDR_CTRL);

  // Read of the state word
  logic state_rd;
  assign state_rd = reg_rd && (reg_addr == adcd_pkg::ADDR_CTRL)
                    && (s_q.ctrl.read_target == adcd_pkg::RT_STATE);

  // Calibration launch from idle
  logic cal_start;
  assign cal_start = ctrl_wr && reg_wdata[0] && !s_q.ctrl.cal_launch;

  ////////////////////////////////////////////////////////////////////
  // Next state

  // All next-state logic
  always_comb begin
    adcd_pkg::adcd_ctrl_s w;
    logic [2:0]           left;
    w         = adcd_pkg::adcd_ctrl_s'(reg_wdata[13:0]);
    left      = 3'h0;
    s_d       = s_q;
    s_d.rdata = adcd_pkg::RST_RDATA;

    // Conversion timer
    if (s_q.ctrl.conv_start) begin
      if (s_q.conv_cnt == '0) begin
        // End of conversion
        s_d.ctrl.conv_start = 1'b0;
      end else begin
        s_d.conv_cnt = s_q.conv_cnt - 6'h1;
      end
    end

    // Control word write
    if (ctrl_wr) begin
      // Running work is not restarted
      if (s_q.ctrl.cal_launch) begin
        w.cal_launch = 1'b1;
      end
      if (s_d.ctrl.conv_start) begin
        w.conv_start = 1'b1;
      end else if (w.conv_start) begin
        // New conversion
        s_d.conv_cnt = adcd_pkg::CONV_LD;
      end
      s_d.ctrl = w;
    end

    // Calibration sequencer
    if (cal_start) begin
      // Plan from selection only; kind latched as sys
      s_d.plan     = plan_of(w.cal_target);
      s_d.cal.sys  = w.cal_kind;
      s_d.cal.step = first_step(s_d.plan);
      s_d.cal_cnt  = adcd_pkg::CAL_LD;
    end else if (s_q.ctrl.cal_launch) begin
      if (s_q.cal_cnt == '0) begin
        // Step done, move on
        left         = s_q.plan & ~step_bit(s_q.cal.step);
        s_d.plan     = left;
        s_d.cal.step = first_step(left);
        s_d.cal_cnt  = adcd_pkg::CAL_LD;
        if (left == 3'h0) begin
          // Sequence done, launch clears
          s_d.ctrl.cal_launch = 1'b0;
        end
      end else begin
        s_d.cal_cnt = s_q.cal_cnt - 6'h1;
      end
    end

    // Register read
    if (reg_rd) begin
      if (state_rd) begin
        // Read-only state word
        s_d.rdata = state_word(s_q.ctrl);
      end
      // Mode bit clears after any read
      s_d.ctrl.if_mode = 1'b0;
    end

    // Registered outputs
    s_d.mux        = route(s_d.ctrl.input_config_select,
                           s_d.ctrl.channel_sel);
    s_d.cal.active = s_d.ctrl.cal_launch;
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  // State register, cleared at power-up except routing, which loads pos 1, neg 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q            <= '0;
      s_q.ctrl       <= adcd_pkg::RST_CTRL;
      s_q.rdata      <= adcd_pkg::RST_RDATA;
      s_q.mux.pos    <= 4'h1;
      s_q.mux.neg    <= 4'h2;
      s_q.cal.step   <= adcd_pkg::STEP_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the register
  assign reg_rdata = s_q.rdata;
  assign ain_sel   = s_q.mux;
  assign cal_state = s_q.cal;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  // Step length for checks
  localparam int STEP_C = int'(adcd_pkg::CAL_STEP_CYC);

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  // Fixed bits of the state word
  AST_ZERO_BIT: assert property (
    state_rd |=> (reg_rdata[15] == 1'b0) && (reg_rdata[4] == 1'b0))
    else $error("state word bit 15 or 4 not zero");

  // Identifier bits
  AST_ID_BITS: assert property (
    state_rd |=> reg_rdata[7:6] == 2'h3)
    else $error("state word id bits not 11");

  // Busy bit follows work in progress
  AST_BUSY_BIT: assert property (
    state_rd |=> reg_rdata[14] ==
      ($past(s_q.ctrl.conv_start) || $past(s_q.ctrl.cal_launch)))
    else $error("busy bit wrong");

  // Mirrored control fields
  AST_FIELDS: assert property (
    state_rd |=> (reg_rdata[13:8] == $past(s_q.ctrl[13:8]))
      && (reg_rdata[3:0] == $past(s_q.ctrl[3:0])))
    else $error("mirrored fields wrong");

  // Mode bit cleared by reads
  AST_MODE_CLR: assert property (
    reg_rd |=> !s_q.ctrl.if_mode)
    else $error("mode bit survived a read");

  // Differential routing
  AST_DIFF: assert property (
    !s_q.ctrl.input_config_select |->
      (ain_sel.pos[0] == ~s_q.ctrl.channel_sel[2])
      && (5'(ain_sel.pos) + 5'(ain_sel.neg)
          == 5'({s_q.ctrl.channel_sel[1:0], 2'b11})))
    else $error("differential routing wrong");

  // Single-ended routing
  AST_SGL: assert property (
    s_q.ctrl.input_config_select |->
      (ain_sel.neg == 4'h0) && (ain_sel.pos[0] == ~s_q.ctrl.channel_sel[2]))
    else $error("single-ended routing wrong");

  // Full sequence order
  AST_FULL: assert property (
    cal_start && (reg_wdata[2:1] == 2'h0) |=>
      (cal_state.step == adcd_pkg::STEP_DAC)
      && (cal_state.sys == $past(reg_wdata[3]))
      ##[STEP_C:STEP_C] (cal_state.step == adcd_pkg::STEP_GAIN)
      ##[STEP_C:STEP_C] (cal_state.step == adcd_pkg::STEP_OFFS))
    else $error("full calibration order wrong");

  // Gain then offset
  AST_GAIN_OFFS: assert property (
    cal_start && (reg_wdata[2:1] == 2'h1) |=>
      (cal_state.step == adcd_pkg::STEP_GAIN)
      ##[STEP_C:STEP_C] (cal_state.step == adcd_pkg::STEP_OFFS))
    else $error("gain-offset order wrong");

  // Single steps end after one step
  AST_SINGLE: assert property (
    cal_start && reg_wdata[2] |=>
      (cal_state.step == ($past(reg_wdata[1]) ? adcd_pkg::STEP_GAIN
                                              : adcd_pkg::STEP_OFFS))
      ##[STEP_C:STEP_C] !cal_state.active)
    else $error("single-step calibration wrong");

  // Launch clears with no step left
  AST_LAUNCH_END: assert property (
    $fell(s_q.ctrl.cal_launch) |-> cal_state.step == adcd_pkg::STEP_NONE)
    else $error("launch cleared mid-sequence");

  // Kind latched at launch
  AST_SYS_KIND: assert property (
    cal_start |=> cal_state.active && (cal_state.sys == $past(reg_wdata[3])))
    else $error("calibration kind not taken");

  // System gain then offset
  AST_SYS_ORDER: assert property (
    cal_start && (reg_wdata[3:1] == 3'h5) |=>
      cal_state.sys && (cal_state.step == adcd_pkg::STEP_GAIN)
      ##[STEP_C:STEP_C] cal_state.sys && (cal_state.step == adcd_pkg::STEP_OFFS))
    else $error("system gain-offset order wrong");

  // System single steps end after one step
  AST_SYS_SINGLE: assert property (
    cal_start && (reg_wdata[3:2] == 2'h3) |=>
      cal_state.sys
      && (cal_state.step == ($past(reg_wdata[1]) ? adcd_pkg::STEP_GAIN
                                                 : adcd_pkg::STEP_OFFS))
      ##[STEP_C:STEP_C] !cal_state.active)
    else $error("system single-step calibration wrong");

  // Running bit matches the engine
  AST_CAL_BIT: assert property (
    state_rd |=> reg_rdata[0] == $past(cal_state.active))
    else $error("calibration running bit wrong");

  // Mode bit shown before it clears
  AST_MODE_SHOW: assert property (
    state_rd |=> reg_rdata[5] == $past(s_q.ctrl.if_mode))
    else $error("mode bit not shown");

  // Read bus quiet unless the state word was read
  AST_RD_IDLE: assert property (
    !state_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a state word read");

  // A write mid-step keeps the step counting
  AST_NO_RESTART: assert property (
    ctrl_wr && s_q.ctrl.cal_launch && (s_q.cal_cnt != 6'h0) |=>
      cal_state.active && (s_q.cal_cnt == $past(s_q.cal_cnt) - 6'h1))
    else $error("running calibration restarted");

  // Main scenarios
  COV_FULL_SYS: cover property (cal_start && reg_wdata[3:1] == 3'h4);
  COV_STATE_RD: cover property (state_rd && s_q.ctrl.cal_launch);
  COV_CAL_DONE: cover property ($fell(cal_state.active));
  COV_REWRITE:  cover property (ctrl_wr && s_q.ctrl.cal_launch);
  COV_CONV_END: cover property ($fell(s_q.ctrl.conv_start));

endmodule

// ===== tb/adcd_host.sv
`timescale 1ns/1ps
// Host side of the register port
module adcd_host (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  output logic             reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  // Quiet bus from time zero
  initial begin
    reg_addr  = 1'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One-cycle write; released lines show the inverse value
  task automatic wr(input logic a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~d;
    reg_addr  <= ~a;
  endtask
  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask
endmodule

// ===== tb/adc_channel_cal_status_decode_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the decode block
module adc_channel_cal_status_decode_bench;
  logic                clk;
  logic                rst_n;
  logic                reg_addr;
  logic [15:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [15:0]         reg_rdata;
  adcd_pkg::adcd_mux_s ain_sel;
  adcd_pkg::adcd_cal_s cal_state;
  int                  err_count;
  int                  checked;
  logic [15:0]         v;

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  adcd_top i_adcd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ain_sel(ain_sel),
    .cal_state(cal_state));
  adcd_host i_adcd_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Values right after reset
  task automatic t_reset;
    chk("rdata", reg_rdata, 16'h0000);
    chk("route", {8'h00, ain_sel}, 16'h0012);
    chk("cal", {12'h000, cal_state}, 16'h0000);
    i_adcd_host.rd(1'h0, v);
    chk("default read", v, 16'h0000);
  endtask
  // Every input routing code, read back in the state word
  task automatic t_route;
    logic [15:0] d;
    logic [3:0]  p;
    logic [3:0]  n;
    for (int i = 0; i < 16; i++) begin
      d = {2'h0, 4'(i), 2'(i), 2'h3, 6'h00};
      p = 4'(2 * (i % 4) + 1 + (i / 4) % 2);
      n = (i >= 8) ? 4'h0 : 4'(2 * (i % 4) + 2 - (i / 4) % 2);
      i_adcd_host.wr(1'h0, d);
      i_adcd_host.rd(1'h0, v);
      chk("route", {8'h00, ain_sel}, {8'h00, p, n});
      chk("state", v, d);
    end
    i_adcd_host.wr(1'h1, 16'h0000);
    chk("unmapped write", {8'h00, ain_sel}, 16'h0080);
    i_adcd_host.rd(1'h1, v);
    chk("unmapped read", v, 16'h0000);
  endtask
  // Each kind and plan of calibration, step by step
  task automatic t_cal;
    logic [15:0] d;
    logic [5:0]  pl;
    int          n;
    for (int j = 0; j < 8; j++) begin
      d = 16'h00c1 | 16'(j << 1);
      case (j % 4)
        0: begin pl = 6'h1b; n = 3; end
        1: begin pl = 6'h0b; n = 2; end
        2: begin pl = 6'h03; n = 1; end
        default: begin pl = 6'h02; n = 1; end
      endcase
      i_adcd_host.wr(1'h0, d);
      i_adcd_host.rd(1'h0, v);
      chk("cal state", v, d | 16'h4000);
      repeat (9) @(posedge clk);
      for (int k = n - 1; k >= 0; k--) begin
        #1;
        chk("step", {12'h000, cal_state}, {12'h000, 1'b1, 1'(j / 4), pl[2*k+:2]});
        if (k == n - 1) i_adcd_host.wr(1'h0, d);
        repeat (20) @(posedge clk);
      end
      #1;
      chk("cal end", {13'h0000, cal_state.active, cal_state.step}, 16'h0000);
      i_adcd_host.rd(1'h0, v);
      chk("cal done", v, d & 16'hfffe);
    end
  endtask
  // Conversion busy, then mode bit cleared by reads
  task automatic t_conv_mode;
    i_adcd_host.wr(1'h0, 16'h00d0);
    i_adcd_host.rd(1'h0, v);
    chk("conv busy", v, 16'h40c0);
    repeat (40) @(posedge clk);
    i_adcd_host.rd(1'h0, v);
    chk("conv idle", v, 16'h00c0);
    i_adcd_host.wr(1'h0, 16'h00e0);
    i_adcd_host.rd(1'h0, v);
    chk("mode set", v, 16'h00e0);
    i_adcd_host.rd(1'h0, v);
    chk("mode", v, 16'h00c0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_route();
    t_cal();
    t_conv_mode();
    complete_run();
  end
  // Watchdog, well past the expected run
  initial begin
    #500000;
    err_count++;
    complete_run();
  end
endmodule
